// ==== logic/rst_irq_boot.sv ====
// Reset release, boot-mode latch and two external interrupt conditioners.
// Assumes the core clears pending edge requests by pulsing IRQ_ACK bits.
module rst_irq_boot
#(
    parameter int RELEASE_CYCLES  = rst_irq_pkg::RELEASE_CYCLES,
    parameter int SYNC_STAGES     = rst_irq_pkg::SYNC_STAGES,
    parameter int REF_STARTUP_CYC = rst_irq_pkg::REF_STARTUP_CYC
)
(
    input  wire logic                     CLK_SYS,
    input  wire logic                     SRST,
    input  wire logic                     RESET_N,
    input  wire logic                     OFFCHIP_BOOT_SELECT,
    input  wire logic                     EXT_IRQ_A_N,
    input  wire logic                     EXT_IRQ_B_N,
    input  wire rst_irq_pkg::irq_cfg_type IRQ_CFG,
    input  wire logic [1:0]               IRQ_ACK,
    input  wire logic                     IN_STOP,
    output logic                          CORE_RST,
    output logic                          BOOT_OFFCHIP_MODE,
    output rst_irq_pkg::irq_out_type      IRQ_OUT,
    output logic                          ADC_REF_READY
);
    import rst_irq_pkg::*;

    // ------------------------------------------------------------
    // Synchronisers, one per request pin
    // ------------------------------------------------------------
    logic [1:0]             pin_n;
    logic [1:0]             sync_n;
    logic [1:0]             prev_n_q;
    logic [1:0]             fall;
    logic [1:0]             trig;
    logic [1:0]             level_req;
    logic [1:0]             pend_q;
    logic [1:0]             pend_d;
    logic                   pin_rst;

    // The reset pin clears request state too, so no edge seen in reset survives it
    assign pin_rst = SRST | ~RESET_N;
    assign pin_n   = {EXT_IRQ_B_N, EXT_IRQ_A_N};
    assign trig  = {IRQ_CFG.trig_b, IRQ_CFG.trig_a};

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_irq
            logic [SYNC_STAGES-1:0] chain_q;
            // Only the last stage is looked at, to avoid metastable reads
            always_ff @(posedge CLK_SYS)
            begin
                if (pin_rst)
                    chain_q <= {SYNC_STAGES{1'b1}};
                else
                    chain_q <= {chain_q[SYNC_STAGES-2:0], pin_n[g]};
            end
            assign sync_n[g]    = chain_q[SYNC_STAGES-1];
            assign fall[g]      = prev_n_q[g] & ~sync_n[g];
            assign level_req[g] = ~sync_n[g];
            // Edge latch: a new edge wins over a same-cycle acknowledge
            assign pend_d[g]    = fall[g] | (pend_q[g] & ~IRQ_ACK[g]);
        end
    endgenerate

    always_ff @(posedge CLK_SYS)
    begin
        if (pin_rst)
        begin
            prev_n_q <= 2'h3;
            pend_q   <= 2'h0;
        end
        else
        begin
            prev_n_q <= sync_n;
            pend_q   <= pend_d;
        end
    end

    // Level mode follows the pin; edge mode holds until acknowledged
    logic [1:0] req_d;
    assign req_d = (trig & pend_d) | (~trig & level_req);
    logic       wake_d;
    assign wake_d = IN_STOP & req_d[0];

    // ------------------------------------------------------------
    // Reset release sequencer
    // ------------------------------------------------------------
    rst_state_type        state_q;
    rst_state_type        state_d;
    logic [CNT_W-1:0]     cnt_q;
    logic [CNT_W-1:0]     cnt_d;
    logic                 boot_q;
    logic                 releasing;

    assign releasing = (state_q == ST_RESET) & RESET_N;

    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            ST_RESET:
            begin
                cnt_d = '0;
                if (RESET_N)
                    state_d = ST_COUNT;
            end
            ST_COUNT:
            begin
                cnt_d = cnt_q + CNT_W'(1);
                if (cnt_q == CNT_W'(RELEASE_CYCLES - 1))
                    state_d = ST_RUN;
            end
            ST_RUN:
                state_d = ST_RUN;
            default:
                state_d = ST_RESET;
        endcase
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (pin_rst)
        begin
            state_q <= ST_RESET;
            cnt_q   <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // Strap caught on the release cycle, then frozen until the next reset
    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
            boot_q <= BOOT_ONCHIP;
        else if (releasing)
            boot_q <= OFFCHIP_BOOT_SELECT;
    end

    // ------------------------------------------------------------
    // Converter reference startup timer
    // ------------------------------------------------------------
    logic [REF_CNT_W-1:0] ref_cnt_q;
    logic                 ref_done;
    assign ref_done = (ref_cnt_q == REF_CNT_W'(REF_STARTUP_CYC));

    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
            ref_cnt_q <= '0;
        else if (!ref_done)
            ref_cnt_q <= ref_cnt_q + REF_CNT_W'(1);
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS)
    begin
        if (pin_rst)
        begin
            CORE_RST      <= RESET_ACTIVE;
            IRQ_OUT       <= '0;
        end
        else
        begin
            CORE_RST      <= (state_d != ST_RUN);
            IRQ_OUT.req_a <= req_d[0];
            IRQ_OUT.req_b <= req_d[1];
            IRQ_OUT.wake  <= wake_d;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            BOOT_OFFCHIP_MODE <= BOOT_ONCHIP;
            ADC_REF_READY     <= 1'b0;
        end
        else
        begin
            BOOT_OFFCHIP_MODE <= releasing ? OFFCHIP_BOOT_SELECT : boot_q;
            ADC_REF_READY     <= ref_done;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Helper: edges seen with the reset pin high since it was last low
    logic [CNT_W-1:0] high_cnt_q;

    always_ff @(posedge CLK_SYS)
    begin
        if (pin_rst)
            high_cnt_q <= '0;
        else if (high_cnt_q != '1)
            high_cnt_q <= high_cnt_q + CNT_W'(1);
    end

    sequence s_release;
        !RESET_N ##1 RESET_N [*8];
    endsequence

    // Level request on A: a falling pin that then stays low through both stages
    sequence s_level_fall_a;
        (!IRQ_CFG.trig_a && $fell(EXT_IRQ_A_N)) ##1 (!EXT_IRQ_A_N && !IRQ_CFG.trig_a) [*2];
    endsequence

    a_reset_holds_core: assert property (@(posedge CLK_SYS) disable iff (SRST)
        !RESET_N |=> CORE_RST)
        else $error("core reset not held while reset pin low");

    a_release_not_early: assert property (@(posedge CLK_SYS) disable iff (SRST)
        s_release |-> CORE_RST)
        else $error("core reset released too early");

    a_release_held: assert property (@(posedge CLK_SYS) disable iff (SRST)
        (high_cnt_q != '0 && high_cnt_q <= CNT_W'(RELEASE_CYCLES)) |-> CORE_RST)
        else $error("core reset released before fixed count");

    a_release_delay: assert property (@(posedge CLK_SYS) disable iff (SRST)
        high_cnt_q == CNT_W'(RELEASE_CYCLES + 1) |-> !CORE_RST)
        else $error("core reset not released after fixed count");

    a_boot_latch: assert property (@(posedge CLK_SYS) disable iff (SRST)
        (state_q == ST_RESET && RESET_N) |=>
            BOOT_OFFCHIP_MODE == $past(OFFCHIP_BOOT_SELECT))
        else $error("boot mode not captured at release");

    a_boot_stable: assert property (@(posedge CLK_SYS) disable iff (SRST)
        (state_q == ST_RUN && $past(state_q) == ST_RUN) |=> $stable(BOOT_OFFCHIP_MODE))
        else $error("boot mode changed while running");

    a_sync_delay_a: assert property (@(posedge CLK_SYS) disable iff (pin_rst)
        s_level_fall_a |=> IRQ_OUT.req_a)
        else $error("level request A not seen after sync delay");

    a_edge_hold_b: assert property (@(posedge CLK_SYS) disable iff (pin_rst)
        (IRQ_CFG.trig_b && IRQ_OUT.req_b && !IRQ_ACK[1]) |=> IRQ_OUT.req_b)
        else $error("edge request B dropped without acknowledge");

    a_wake_stop: assert property (@(posedge CLK_SYS) disable iff (pin_rst)
        IRQ_OUT.wake |-> IRQ_OUT.req_a && $past(IN_STOP))
        else $error("wake without request A in stop");

    a_ref_ready: assert property (@(posedge CLK_SYS) disable iff (SRST)
        ADC_REF_READY |-> ref_cnt_q == REF_CNT_W'(REF_STARTUP_CYC))
        else $error("reference ready before startup time");

endmodule

// ==== logic/rst_irq_pkg.sv ====
// Package for the reset, boot-strap and external interrupt pin logic.
// Assumes one 100 MHz core clock; the reset pin is sampled like any input.
// Behaviour
// - Interrupt A input passes a synchroniser first
// - Interrupt A selectable low level or falling edge
// - Interrupt A request wakes core from Stop
// - Interrupt B selectable low level or falling edge
// - Reset pin low holds device in Reset
// - Boot mode captured at reset pin release
// - Internal reset released synchronously after fixed count
// - Boot strap high selects off-chip boot
package rst_irq_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 10;
    localparam int RELEASE_CYCLES    = 16;
    localparam int SYNC_STAGES       = 2;
    localparam int CNT_W             = 8;
    localparam int REF_STARTUP_MS    = 25;
    localparam int REF_STARTUP_CYC   = REF_STARTUP_MS * 1000000 / CLK_PERIOD_NS;
    localparam int REF_CNT_W         = 22;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic TRIG_LEVEL      = 1'h0;
    localparam logic TRIG_EDGE       = 1'h1;
    localparam logic BOOT_ONCHIP     = 1'h0;
    localparam logic BOOT_OFFCHIP    = 1'h1;
    localparam logic RESET_ACTIVE    = 1'h1;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_COUNT,
        ST_RUN
    } rst_state_type;

    typedef struct packed {
        logic req_a;
        logic req_b;
        logic wake;
    } irq_out_type;

    typedef struct packed {
        logic trig_a;
        logic trig_b;
    } irq_cfg_type;

endpackage

// ==== verification/board_model.sv ====
// Board-side partner: reset source, debug reset, boot strap, two interrupting devices.
// Assumes the bench commands it by non-blocking assignment at the rising clock edge.
module board_model
(
    input  wire logic       clk,
    input  wire logic       rst_req,
    input  wire logic       debug_only,
    input  wire logic       boot_hi,
    input  wire logic [1:0] irq_req,
    input  wire logic       adc_ready,
    output logic            reset_n,
    output logic            trst_n,
    output logic            boot_sel,
    output logic            irq_a_n,
    output logic            irq_b_n,
    output logic            conv_start
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    assign reset_n  = ~rst_req;
    assign trst_n   = ~(rst_req & ~debug_only);
    assign boot_sel = boot_hi;
    // Push-pull requesters: a released line is driven back high by the model itself
    assign irq_a_n  = ~irq_req[0];
    assign irq_b_n  = ~irq_req[1];

    // No conversion is started before the reference has settled
    always_ff @(posedge clk)
    begin
        conv_start <= adc_ready;
    end
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the reset, boot-strap and interrupt pin logic.
// Assumes the design's package is compiled first; reference wait shortened to 20 cycles.
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, a, b); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rst_irq_pkg::*;

    localparam int REF_SIM_CYC = 20;

    logic        clk_sys = 1'h0;
    logic        srst = 1'h1;
    logic        rst_req = 1'h1;
    logic        debug_only = 1'h0;
    logic        boot_hi = 1'h0;
    logic [1:0]  irq_req = 2'h0;
    logic [1:0]  irq_cfg = 2'h0;
    logic [1:0]  irq_ack = 2'h0;
    logic        in_stop = 1'h0;
    logic        reset_n, trst_n, boot_sel, irq_a_n, irq_b_n, conv_start;
    logic        core_rst, boot_mode, adc_ready;
    irq_out_type irq_out;
    int          miscompares = 0;
    int          total_checks = 0;

    initial forever #5 clk_sys = ~clk_sys;

    board_model board_model_inst (.clk(clk_sys), .rst_req(rst_req), .debug_only(debug_only),
        .boot_hi(boot_hi), .irq_req(irq_req), .adc_ready(adc_ready), .reset_n(reset_n),
        .trst_n(trst_n), .boot_sel(boot_sel), .irq_a_n(irq_a_n), .irq_b_n(irq_b_n),
        .conv_start(conv_start));

    rst_irq_boot #(.RELEASE_CYCLES(RELEASE_CYCLES), .SYNC_STAGES(SYNC_STAGES),
        .REF_STARTUP_CYC(REF_SIM_CYC)) rst_irq_boot_inst (.CLK_SYS(clk_sys), .SRST(srst),
        .RESET_N(reset_n), .OFFCHIP_BOOT_SELECT(boot_sel), .EXT_IRQ_A_N(irq_a_n),
        .EXT_IRQ_B_N(irq_b_n), .IRQ_CFG(irq_cfg), .IRQ_ACK(irq_ack), .IN_STOP(in_stop),
        .CORE_RST(core_rst), .BOOT_OFFCHIP_MODE(boot_mode), .IRQ_OUT(irq_out),
        .ADC_REF_READY(adc_ready));

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    function automatic logic req_of(input int sel);
        return sel ? irq_out.req_b : irq_out.req_a;
    endfunction

    task automatic pin_reset(input logic boot, input logic dbg);
        @(posedge clk_sys);
        rst_req <= 1'h1;
        debug_only <= dbg;
        boot_hi <= boot;
        irq_cfg <= 2'h0;
        irq_req <= 2'h3;
        repeat (4) @(posedge clk_sys);
        #1;
        `CHK(core_rst, 1'h1)
        `CHK(irq_out, 3'h0)
        `CHK(trst_n, dbg)
        @(posedge clk_sys);
        irq_req <= 2'h0;
        @(posedge clk_sys);
        rst_req <= 1'h0;
        repeat (RELEASE_CYCLES) @(posedge clk_sys);
        #1;
        `CHK(core_rst, 1'h1)
        `CHK(boot_mode, boot)
        @(posedge clk_sys);
        #1;
        `CHK(core_rst, 1'h0)
        `CHK(irq_out, 3'h0)
        @(posedge clk_sys);
        boot_hi <= ~boot;
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK(boot_mode, boot)
    endtask

    task automatic level_irq(input int sel, input logic stop);
        @(posedge clk_sys);
        irq_cfg <= 2'h0;
        in_stop <= stop;
        irq_req[sel] <= 1'h1;
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK(req_of(sel), 1'h0)
        @(posedge clk_sys);
        #1;
        `CHK(req_of(sel), 1'h1)
        `CHK(irq_out.wake, stop & (sel == 0))
        @(posedge clk_sys);
        irq_req[sel] <= 1'h0;
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK(req_of(sel), 1'h1)
        @(posedge clk_sys);
        in_stop <= 1'h0;
        #1;
        `CHK(req_of(sel), 1'h0)
    endtask

    // Edges latched while in level mode are acknowledged first, so only this edge counts
    task automatic edge_irq(input int sel);
        @(posedge clk_sys);
        irq_cfg <= 2'h3;
        irq_ack[sel] <= 1'h1;
        @(posedge clk_sys);
        irq_ack[sel] <= 1'h0;
        irq_req[sel] <= 1'h1;
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK(req_of(sel), 1'h0)
        @(posedge clk_sys);
        irq_req[sel] <= 1'h0;
        #1;
        `CHK(req_of(sel), 1'h1)
        repeat (6) @(posedge clk_sys);
        #1;
        `CHK(req_of(sel), 1'h1)
        @(posedge clk_sys);
        irq_ack[sel] <= 1'h1;
        @(posedge clk_sys);
        irq_ack[sel] <= 1'h0;
        #1;
        `CHK(req_of(sel), 1'h0)
        @(posedge clk_sys);
        #1;
        `CHK(req_of(sel), 1'h0)
    endtask

    task automatic stop_test;
        if (miscompares == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        #200000;
        miscompares++;
        stop_test();
    end

    initial
    begin
        repeat (20) @(posedge clk_sys);
        srst <= 1'h0;
        @(posedge clk_sys);
        #1;
        `CHK(adc_ready, 1'h0)
        repeat (REF_SIM_CYC - 1) @(posedge clk_sys);
        #1;
        `CHK(adc_ready, 1'h0)
        @(posedge clk_sys);
        #1;
        `CHK(adc_ready, 1'h1)
        `CHK(conv_start, 1'h0)
        pin_reset(1'h1, 1'h0);
        pin_reset(1'h0, 1'h1);
        `CHK(trst_n, 1'h1)
        for (int s = 0; s < 2; s++)
        begin
            level_irq(s, 1'h0);
            level_irq(s, 1'h1);
            edge_irq(s);
        end
        `CHK(adc_ready, 1'h1)
        `CHK(conv_start, 1'h1)
        stop_test();
    end
endmodule
